// >>> core/spp_pkg.sv
// Constants and types shared by the serial programming port
package spp_pkg;
   // Instruction and echo bytes
   localparam logic [7:0]  CMD_UNLOCK   = 8'hAC;
   localparam logic [7:0]  SUB_UNLOCK   = 8'h53;
   localparam logic [7:0]  SUB_ERASE    = 8'h80;
   localparam logic [7:0]  CMD_RD_LO    = 8'h20;
   localparam logic [7:0]  CMD_RD_HI    = 8'h28;
   localparam logic [7:0]  CMD_EE_RD    = 8'hA0;
   localparam logic [7:0]  CMD_EE_WR    = 8'hC0;
   // Erased contents
   localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
   localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
   // Array geometry
   localparam int          FLASH_WORDS  = 8192;
   localparam int          EE_BYTES     = 512;
   localparam logic [12:0] FLASH_LAST   = 13'h1FFF;
   // Framing positions and reset values
   localparam logic [4:0]  BIT_RST      = 5'h00;
   localparam logic [4:0]  BIT_BYTE2    = 5'h0F;
   localparam logic [4:0]  BIT_BYTE3    = 5'h17;
   localparam logic [4:0]  BIT_LAST     = 5'h1F;
   localparam logic [2:0]  BIT_IN_BYTE  = 3'h7;
   localparam logic [31:0] RX_RST       = 32'h0000_0000;
   localparam logic [7:0]  OUT_RST      = 8'h00;
   // Timing
   localparam int          CLK_MHZ      = 40;
   localparam int          EE_WRITE_US  = 10;
   localparam logic [8:0]  EE_WRITE_CYC = 9'(EE_WRITE_US * CLK_MHZ);
   // Port states
   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_EEWR} spp_state_t;
endpackage

// >>> core/spp_port.sv
// Serial programming port: framing, echo, bulk erase and self-timed EEPROM write
//
// Overview of operation
// [R1] Bulk erase sets every program and EEPROM location to all ones.
// [R2] EEPROM write erases its location itself inside the self-timed write.
// [R3] Programmer keeps the CPU clock valid; all pins are sampled on it.
// [R4] Programmer holds serial clock low over the minimum CPU-cycle count.
// [R5] Programmer holds serial clock high over the minimum CPU-cycle count.
// [R6] Incoming bits are sampled on the serial clock rising edge.
// [R7] Outgoing bits change on the serial clock falling edge.
// [R8] Programmer keeps reset and serial clock low during power-up.
// [R9] Otherwise it drives clock low, then pulses reset high two cycles.
// [R10] Programmer waits 20 ms, then sends the unlock instruction; the model waits only 200 ns.
// [R11] When synchronised, byte 0x53 echoes while the third byte transfers.
// [R12] Programmer always sends all four bytes of an instruction; the resync test sends four stray bits.
// [R13] On a bad echo programmer pulses reset and resends unlock.
// [R14] No instruction executes while byte framing is out of synchronisation.
// [R15] Bytes go MSB first; only unlock works until unlock accepted.
`timescale 1ns/1ps
module spp_port
   import spp_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic arst_n,
   // Programming pins
   input  wire logic prog_rst_n,
   input  wire logic sck,
   input  wire logic mosi,
   output logic      miso,
   // Status
   output logic      prog_active,
   output logic      busy
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; pulse widths on the serial clock exceed two cycles
   logic [1:0] rst_s_q, sck_s_q, mosi_s_q;
   logic       sck_prev_q;
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_s_q    <= 2'h3;
         sck_s_q    <= 2'h0;
         mosi_s_q   <= 2'h0;
         sck_prev_q <= 1'b0;
      end
      else
      begin
         rst_s_q    <= {rst_s_q[0], prog_rst_n};
         sck_s_q    <= {sck_s_q[0], sck};
         mosi_s_q   <= {mosi_s_q[0], mosi};
         sck_prev_q <= sck_s_q[1];
      end
   end

   // Edge finding on the second stage only [R3] [R4] [R5]
   logic prog_en, sck_rise, sck_fall;
   assign prog_en  = !rst_s_q[1];
   assign sck_rise = sck_s_q[1] && !sck_prev_q;
   assign sck_fall = !sck_s_q[1] && sck_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Storage arrays
   logic [15:0] flash_mem [FLASH_WORDS];
   logic [7:0]  ee_mem    [EE_BYTES];

   // Byte of a program word, high or low half
   function automatic logic [7:0] word_byte(input logic [15:0] w, input logic hi);
      word_byte = hi ? w[15:8] : w[7:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Port state
   spp_state_t  st_q, st_d;
   logic [4:0]  bit_q, bit_d;
   logic [31:0] rx_q, rx_d;
   logic [7:0]  out_q, out_d;
   logic        miso_q, miso_d;
   logic        unl_q, unl_d;
   logic        busy_q, busy_d;
   logic [12:0] cnt_q, cnt_d;
   logic [8:0]  tmr_q, tmr_d;
   logic [8:0]  ee_addr_q, ee_addr_d;
   logic [7:0]  ee_data_q, ee_data_d;
   logic        fl_we, ee_we;
   logic [8:0]  ee_waddr;
   logic [7:0]  ee_wdata;

   // Next-state logic for framing, echo and execution
   always_comb
   begin
      st_d      = st_q;
      bit_d     = bit_q;
      rx_d      = rx_q;
      out_d     = out_q;
      miso_d    = miso_q;
      unl_d     = unl_q;
      cnt_d     = cnt_q;
      tmr_d     = tmr_q;
      ee_addr_d = ee_addr_q;
      ee_data_d = ee_data_q;
      fl_we     = 1'b0;
      ee_we     = 1'b0;
      ee_waddr  = ee_addr_q;
      ee_wdata  = ee_data_q;
      if (!prog_en)
      begin
         // Device running: a reset pulse restarts framing and relocks [R14]
         bit_d = BIT_RST;
         unl_d = 1'b0;
      end
      else
      begin
         if (sck_rise)
         begin
            rx_d  = {rx_q[30:0], mosi_s_q[1]};                 // R6
            bit_d = 5'(bit_q + 5'h01);
            if (bit_q[2:0] == BIT_IN_BYTE)
            begin
               // Echo the byte just received; read data replaces the fourth [R11]
               out_d = rx_d[7:0];
               if (bit_q == BIT_BYTE3 && unl_q)
               begin
                  if (rx_d[23:16] == CMD_RD_LO || rx_d[23:16] == CMD_RD_HI)
                     out_d = word_byte(flash_mem[rx_d[12:0]], rx_d[19]);
                  else if (rx_d[23:16] == CMD_EE_RD)
                     out_d = ee_mem[rx_d[8:0]];
               end
            end
            if (bit_q == BIT_LAST && st_q == ST_IDLE)
            begin
               if (rx_d[31:24] == CMD_UNLOCK && rx_d[23:16] == SUB_UNLOCK)
                  unl_d = 1'b1;                                 // R14
               else if (unl_q)                                  // R15
               begin
                  if (rx_d[31:24] == CMD_UNLOCK && rx_d[23:16] == SUB_ERASE)
                  begin
                     st_d  = ST_ERASE;
                     cnt_d = 13'h0000;
                  end
                  else if (rx_d[31:24] == CMD_EE_WR)
                  begin
                     st_d      = ST_EEWR;
                     ee_addr_d = rx_d[16:8];
                     ee_data_d = rx_d[7:0];
                     tmr_d     = 9'(EE_WRITE_CYC - 9'h001);
                     // Erase the location first, no bulk erase needed [R2]
                     ee_we     = 1'b1;
                     ee_waddr  = rx_d[16:8];
                     ee_wdata  = ERASED_BYTE;
                  end
               end
            end
         end
         if (sck_fall)
         begin
            miso_d = out_q[7];                                  // R7
            out_d  = {out_q[6:0], 1'b0};                         // R15
         end
      end
      unique case (st_q)
         ST_IDLE :
         begin
         end
         ST_ERASE :
         begin
            // One program word per cycle; EEPROM shares the low addresses [R1]
            fl_we    = 1'b1;
            ee_we    = (cnt_q < 13'(EE_BYTES));
            ee_waddr = cnt_q[8:0];
            ee_wdata = ERASED_BYTE;
            cnt_d    = 13'(cnt_q + 13'h0001);
            if (cnt_q == FLASH_LAST)
               st_d = ST_IDLE;
         end
         ST_EEWR :
         begin
            tmr_d = 9'(tmr_q - 9'h001);
            if (tmr_q == 9'h000)
            begin
               ee_we = 1'b1;                                    // R2
               st_d  = ST_IDLE;
            end
         end
      endcase
      busy_d = (st_d != ST_IDLE);
   end

   // Port registers
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q      <= ST_IDLE;
         bit_q     <= BIT_RST;
         rx_q      <= RX_RST;
         out_q     <= OUT_RST;
         miso_q    <= 1'b0;
         unl_q     <= 1'b0;
         busy_q    <= 1'b0;
         cnt_q     <= 13'h0000;
         tmr_q     <= 9'h000;
         ee_addr_q <= 9'h000;
         ee_data_q <= OUT_RST;
      end
      else
      begin
         st_q      <= st_d;
         bit_q     <= bit_d;
         rx_q      <= rx_d;
         out_q     <= out_d;
         miso_q    <= miso_d;
         unl_q     <= unl_d;
         busy_q    <= busy_d;
         cnt_q     <= cnt_d;
         tmr_q     <= tmr_d;
         ee_addr_q <= ee_addr_d;
         ee_data_q <= ee_data_d;
      end
   end

   // Array writes; contents are not reset, which matches real nonvolatile cells
   always_ff @(posedge mclk)
   begin
      if (fl_we)
         flash_mem[cnt_q] <= ERASED_WORD;                       // R1
      if (ee_we)
         ee_mem[ee_waddr] <= ee_wdata;
   end

   assign miso        = miso_q;
   assign prog_active = unl_q;
   assign busy        = busy_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   rx_on_rise_a : assert property (@(posedge mclk) disable iff (!arst_n) // R6
      $changed(rx_q) |-> $past(sck_rise))
      else $error("receive shift moved without a rising serial clock");
   miso_on_fall_a : assert property (@(posedge mclk) disable iff (!arst_n) // R7
      $changed(miso_q) |-> $past(sck_fall))
      else $error("output bit moved without a falling serial clock");
   msb_first_a : assert property (@(posedge mclk) disable iff (!arst_n) // R15
      sck_fall && prog_en |=> miso_q == $past(out_q[7]))
      else $error("output bit is not the top bit of the shift");
   echo_byte_a : assert property (@(posedge mclk) disable iff (!arst_n) // R11
      sck_rise && prog_en && bit_q == BIT_BYTE2 |=> out_q == rx_q[7:0])
      else $error("second byte not loaded for echo");
   unlock_gate_a : assert property (@(posedge mclk) disable iff (!arst_n) // R14
      $rose(unl_q) |-> $past(rx_q[31:16]) == {CMD_UNLOCK, SUB_UNLOCK} || rx_q[31:16] == {CMD_UNLOCK, SUB_UNLOCK})
      else $error("unlocked without a full unlock instruction");
   locked_exec_a : assert property (@(posedge mclk) disable iff (!arst_n) // R15
      st_q != ST_IDLE && $past(st_q) == ST_IDLE |-> $past(unl_q))
      else $error("instruction executed while locked");
   erase_done_a : assert property (@(posedge mclk) disable iff (!arst_n) // R1
      st_q == ST_ERASE && cnt_q == FLASH_LAST |=> st_q == ST_IDLE && flash_mem[0] == ERASED_WORD
         && ee_mem[EE_BYTES - 1] == ERASED_BYTE)
      else $error("bulk erase left a location not all ones");
   ee_autoerase_a : assert property (@(posedge mclk) disable iff (!arst_n) // R2
      st_q == ST_EEWR && $past(st_q) == ST_IDLE |-> ee_mem[ee_addr_q] == ERASED_BYTE)
      else $error("EEPROM location not erased at write start");
   ee_write_end_a : assert property (@(posedge mclk) disable iff (!arst_n) // R2
      st_q == ST_EEWR && tmr_q == 9'h000 |=> st_q == ST_IDLE && ee_mem[ee_addr_q] == ee_data_q)
      else $error("EEPROM write did not land its data");
endmodule

// >>> verification/serial_program_port_test.sv
// Self-checking bench for the serial programming port
`timescale 1ns/1ps
module serial_program_port_test
   import spp_pkg::*;
;
   logic        mclk, arst_n, prog_rst_n, sck, mosi, miso, prog_active, busy;
   logic [31:0] rx;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles = 0;

   // CPU clock kept running through all traffic
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   spp_port u_dut (.mclk(mclk), .arst_n(arst_n), .prog_rst_n(prog_rst_n), .sck(sck), .mosi(mosi), .miso(miso),
                   .prog_active(prog_active), .busy(busy));
   spp_prog_model u_prog (.prog_rst_n(prog_rst_n), .sck(sck), .mosi(mosi), .miso(miso));

   ////////////////////////////////////////////////////////////////////////
   // Hang guard, well above the erase plus all frames
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask

   // Whole instruction, then settle so status reflects it
   task automatic send(input logic [31:0] tx);
      u_prog.xfer(32, tx, rx);
      repeat (8) @(posedge mclk);
      #3;
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 9000 && busy !== 1'b0; i++)
         @(posedge mclk);
      #3;
      chk("busy", 0, busy);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_locked();
      send({CMD_EE_WR, 8'h00, 8'h10, 8'h77});
      chk("locked busy", 0, busy);
      chk("locked active", 0, prog_active);
   endtask

   task automatic t_unlock();
      send({CMD_UNLOCK, SUB_UNLOCK, 16'h0000});
      chk("echo b2", SUB_UNLOCK, rx[15:8]);
      chk("echo b1", CMD_UNLOCK, rx[23:16]);
      chk("active", 1, prog_active);
   endtask

   task automatic t_erase();
      send({CMD_UNLOCK, SUB_ERASE, 16'h0000});
      chk("erase busy", 1, busy);
      wait_idle();
      send({CMD_RD_LO, 8'h1F, 8'hFF, 8'h00});
      chk("flash lo", ERASED_BYTE, rx[7:0]);
      send({CMD_RD_HI, 8'h00, 8'h00, 8'h00});
      chk("flash hi", ERASED_BYTE, rx[7:0]);
      send({CMD_EE_RD, 8'h01, 8'hFF, 8'h00});
      chk("ee last", ERASED_BYTE, rx[7:0]);
   endtask

   // Second write lands while busy and must be dropped
   task automatic t_eewr();
      send({CMD_EE_WR, 8'h01, 8'h23, 8'h5A});
      chk("wr busy", 1, busy);
      send({CMD_EE_WR, 8'h00, 8'h07, 8'h11});
      wait_idle();
      send({CMD_EE_RD, 8'h01, 8'h23, 8'h00});
      chk("ee data", 8'h5A, rx[7:0]);
      send({CMD_EE_RD, 8'h00, 8'h07, 8'h00});
      chk("ee dropped", ERASED_BYTE, rx[7:0]);
      send({CMD_EE_WR, 8'h01, 8'h23, 8'h3C});
      wait_idle();
      send({CMD_EE_RD, 8'h01, 8'h23, 8'h00});
      chk("ee rewrite", 8'h3C, rx[7:0]);
   endtask

   // Four stray bits shift the framing; unlock must then fail until a reset pulse
   task automatic t_resync();
      u_prog.pulse_rst();
      chk("rst active", 0, prog_active);
      u_prog.xfer(4, 32'h0000_0000, rx);
      send({CMD_UNLOCK, SUB_UNLOCK, 16'h0000});
      chk("skew active", 0, prog_active);
      u_prog.pulse_rst();
      send({CMD_UNLOCK, SUB_UNLOCK, 16'h0000});
      chk("resync echo", SUB_UNLOCK, rx[15:8]);
      chk("resync active", 1, prog_active);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      arst_n = 1'b0;
      repeat (16) @(posedge mclk);
      #3 arst_n = 1'b1;
      repeat (4) @(posedge mclk);
      #3;
      t_locked();
      t_unlock();
      t_erase();
      t_eewr();
      t_resync();
      end_of_test();
   end
endmodule

// >>> verification/spp_prog_model.sv
// Programmer model driving the serial programming pins
`timescale 1ns/1ps
module spp_prog_model
   import spp_pkg::*;
(
   // Pins toward the port
   output logic      prog_rst_n,
   output logic      sck,
   output logic      mosi,
   input  wire logic miso
);
   // Power-up with reset and serial clock both low
   initial
   begin
      prog_rst_n = 1'b0;
      sck = 1'b0;
      mosi = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset pulse with clock parked low; entry wait shortened to keep runs short
   task automatic pulse_rst();
      sck = 1'b0;
      prog_rst_n = 1'b1;
      #100 prog_rst_n = 1'b0;
      #200;
   endtask

   // Frame of n bits, MSB first; reply sampled mid-high, well clear of its change
   task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
      rx = 32'h0000_0000;
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi = tx[i];
         #100 sck = 1'b1;
         #50 rx = {rx[30:0], miso};
         #50 sck = 1'b0;
      end
      mosi = ~mosi; // Released line must not look held
   endtask
endmodule
